// ==== logic/rh_port_pkg.sv ====
// Constants and types for the root hub port two status and control block
package rh_port_pkg;
    // Register map (byte addresses and word indices)
    localparam logic [11:0] port_two_index = 12'h0058;
    localparam logic [11:0] port_two_addr = 12'h0558;
    localparam logic [11:0] irq_status_addr = 12'h0600;
    localparam logic [11:0] irq_mask_addr = 12'h0604;
    localparam logic [11:0] port_cfg_addr = 12'h0608;
    // Low half bit positions
    localparam int connect_bit = 0;
    localparam int enable_bit = 1;
    localparam int suspend_bit = 2;
    localparam int overcur_bit = 3;
    localparam int reset_bit = 4;
    localparam int power_bit = 8;
    // High half change flag positions
    localparam int conn_chg_bit = 16;
    localparam int en_chg_bit = 17;
    localparam int susp_chg_bit = 18;
    localparam int oc_chg_bit = 19;
    localparam int rst_chg_bit = 20;
    // Configuration register bit positions
    localparam int cfg_nonremovable_bit = 0;
    localparam int cfg_per_port_oc_bit = 1;
    // Reset values
    localparam logic [4:0] change_reset = 5'h00;
    localparam logic [4:0] irq_mask_reset = 5'h00;
    localparam logic [1:0] cfg_reset = 2'h0;
    // Timing at 20 MHz, 50 ns period
    localparam int clk_period_ns = 50;
    localparam int reset_time_ms = 10;
    localparam int resume_pulse_ms = 20;
    localparam int resync_time_ms = 3;
    localparam int ls_eop_cycles = 30;
    localparam int reset_cycles = reset_time_ms * 1000000 / clk_period_ns;
    localparam int resume_cycles = resume_pulse_ms * 1000000 / clk_period_ns;
    localparam int resync_cycles = resync_time_ms * 1000000 / clk_period_ns;
    // Port sequencer states
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_reset = 3'b001,
        st_suspend = 3'b010,
        st_resume = 3'b011,
        st_eop = 3'b100,
        st_resync = 3'b101
    } port_state_t;
endpackage : rh_port_pkg

// ==== logic/rh_port_timer.sv ====
// Down counter timing the reset, resume and resync intervals
`timescale 1ns/1ps
module rh_port_timer (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // Load and expiry
    input wire logic load_in,
    input wire logic [23:0] count_in,
    output logic done_out
);
    logic [23:0] count_reg;
    logic run_reg;

    // Count down a loaded interval, pulse at the end
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            count_reg <= 24'h00_0000;
            run_reg <= 1'b0;
            done_out <= 1'b0;
        end else if (load_in) begin
            count_reg <= count_in;
            run_reg <= count_in != 24'h00_0000; // Zero load stops the timer
            done_out <= 1'b0;
        end else begin
            done_out <= run_reg && (count_reg == 24'h00_0001);
            if (run_reg) begin
                count_reg <= count_reg - 24'h00_0001;
                if (count_reg == 24'h00_0001) begin
                    run_reg <= 1'b0;
                end
            end
        end
    end
endmodule : rh_port_timer

// ==== logic/rh_port_ctrl.sv ====
// Root hub port two status and control with APB slave
//
// Notes on behaviour
// - Port register at byte 558h, word index 58h; low state, high changes.
// - Port state writes wait until a bus transaction finishes.
// - Bit 0 reads the live connect state.
// - Write 1 to bit 0 clears enable; writes never change connect.
// - Bit 0 reads 1 for a nonremovable device.
// - Bit 1 is enable; hardware clears set enable change.
// - Write 1 to bit 1 enables; disconnected sets connect change.
// - Enable sets when reset or resume completes with change flag.
// - Bit 2 is suspend; clears on resume end, reset end, host resume; here it clears when a reset starts.
// - Write 1 to bit 2 suspends; disconnected sets connect change.
// - Bit 3 follows over-current input if per-port, else 0.
// - Write 1 to bit 3 resumes only when suspended.
// - Write 1 to bit 4 starts reset; disconnected sets connect change.
// - Reset flag reads 1 while reset runs, clears at change set.
// - Reset signalling lasts 10 ms then sets reset change.
// - Resume is 20 ms pulse, low-speed EOP, 3 ms resync.
// - Power off clears connect, enable, suspend and reset state.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module rh_port_ctrl (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Port pins and neighbouring root hub state
    input wire logic connect_in,
    input wire logic overcur_in,
    input wire logic power_in,
    input wire logic babble_in,
    input wire logic transact_busy_in,
    input wire logic hc_resume_in,
    output logic port_reset_drive_out,
    output logic port_resume_drive_out,
    output logic port_eop_drive_out,
    output logic irq_out
);
    // Synchronised pins
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic conn_s, oc_s, pwr_s, babble_s, hcres_s;
    // Port state
    rh_port_pkg::port_state_t state_reg, state_next;
    logic enable_reg, conn_prev_reg, oc_prev_reg;
    logic [4:0] change_reg, change_next, mask_reg;
    logic [1:0] cfg_reg;
    // Postponed port state command
    logic [4:0] pend_reg;
    logic [4:0] cmd_bits;
    // Timer handshake
    logic tmr_load;
    logic [23:0] tmr_count;
    logic tmr_done;

    // Two flops on every asynchronous pin
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {hc_resume_in, babble_in, power_in, overcur_in, connect_in};
            sync2_reg <= sync1_reg;
        end
    end
    assign {hcres_s, babble_s, pwr_s, oc_s, conn_s} = sync2_reg;

    // Bus decode
    wire apb_access = psel_in && penable_in;
    wire apb_wr = apb_access && pwrite_in;
    wire hit_port = paddr_in == rh_port_pkg::port_two_addr;
    wire hit_stat = paddr_in == rh_port_pkg::irq_status_addr;
    wire hit_mask = paddr_in == rh_port_pkg::irq_mask_addr;
    wire hit_cfg = paddr_in == rh_port_pkg::port_cfg_addr;
    wire hit_any = hit_port || hit_stat || hit_mask || hit_cfg;
    wire port_wr = apb_wr && hit_port;

    // Effective connect and over-current views
    wire conn_eff = pwr_s && (conn_s || cfg_reg[rh_port_pkg::cfg_nonremovable_bit]);
    wire oc_eff = oc_s && cfg_reg[rh_port_pkg::cfg_per_port_oc_bit];
    wire suspended = (state_reg == rh_port_pkg::st_suspend) || (state_reg == rh_port_pkg::st_resume)
        || (state_reg == rh_port_pkg::st_eop) || (state_reg == rh_port_pkg::st_resync);
    wire resetting = state_reg == rh_port_pkg::st_reset;

    // Commands apply only when no transaction is in flight
    wire cmd_go = !transact_busy_in;
    assign cmd_bits = cmd_go ? (pend_reg | (port_wr ? pwdata_in[4:0] : 5'h00)) : 5'h00;
    wire c_clr_en = cmd_bits[rh_port_pkg::connect_bit];
    wire c_set_en = cmd_bits[rh_port_pkg::enable_bit];
    wire c_susp = cmd_bits[rh_port_pkg::suspend_bit];
    wire c_resume = cmd_bits[rh_port_pkg::overcur_bit];
    wire c_reset = cmd_bits[rh_port_pkg::reset_bit];

    // Hardware events
    wire conn_edge = conn_eff != conn_prev_reg;
    wire oc_edge = oc_eff != oc_prev_reg;
    wire reset_end = resetting && tmr_done;
    wire resume_end = (state_reg == rh_port_pkg::st_resync) && tmr_done;
    wire hw_dis = enable_reg && (oc_eff || !conn_eff || babble_s);
    wire bad_cmd = !conn_eff && (c_set_en || c_susp || c_reset);

    // Port sequencer
    always_comb begin
        state_next = state_reg;
        tmr_load = 1'b0;
        tmr_count = 24'h00_0000;
        case (state_reg)
            rh_port_pkg::st_idle: begin
                if (c_reset && conn_eff) begin
                    state_next = rh_port_pkg::st_reset;
                    tmr_load = 1'b1;
                    tmr_count = 24'(rh_port_pkg::reset_cycles);
                end else if (c_susp && conn_eff) begin
                    state_next = rh_port_pkg::st_suspend;
                end
            end
            rh_port_pkg::st_reset: begin
                if (tmr_done) begin
                    state_next = rh_port_pkg::st_idle;
                end
            end
            rh_port_pkg::st_suspend: begin
                if (c_reset && conn_eff) begin
                    state_next = rh_port_pkg::st_reset;
                    tmr_load = 1'b1;
                    tmr_count = 24'(rh_port_pkg::reset_cycles);
                end else if (hcres_s) begin
                    state_next = rh_port_pkg::st_idle;
                end else if (c_resume) begin
                    state_next = rh_port_pkg::st_resume;
                    tmr_load = 1'b1;
                    tmr_count = 24'(rh_port_pkg::resume_cycles);
                end
            end
            rh_port_pkg::st_resume: begin
                if (tmr_done) begin
                    state_next = rh_port_pkg::st_eop;
                    tmr_load = 1'b1;
                    tmr_count = 24'(rh_port_pkg::ls_eop_cycles);
                end
            end
            rh_port_pkg::st_eop: begin
                if (tmr_done) begin
                    state_next = rh_port_pkg::st_resync;
                    tmr_load = 1'b1;
                    tmr_count = 24'(rh_port_pkg::resync_cycles);
                end
            end
            rh_port_pkg::st_resync: begin
                if (tmr_done) begin
                    state_next = rh_port_pkg::st_idle;
                end
            end
            default: state_next = rh_port_pkg::st_idle;
        endcase
        // Host resume state drops suspend from any suspend or resume step
        if (hcres_s && suspended && state_next != rh_port_pkg::st_reset) begin
            state_next = rh_port_pkg::st_idle;
            tmr_load = 1'b1;
            tmr_count = 24'h00_0000;
        end
        if (!pwr_s || !conn_eff) begin
            state_next = rh_port_pkg::st_idle;
            tmr_load = 1'b1;
            tmr_count = 24'h00_0000;
        end
    end

    rh_port_timer u_timer (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .done_out(tmr_done)
    );

    // Change flags: hardware set wins over write-one clear
    wire [4:0] chg_clr = port_wr ? pwdata_in[20:16] : 5'h00;
    wire [4:0] chg_set = {reset_end, oc_edge, resume_end, hw_dis, conn_edge || bad_cmd};
    always_comb begin
        change_next = (change_reg & ~chg_clr) | chg_set;
        if (reset_end) begin
            change_next[2] = 1'b0; // suspend change drops when reset change sets
        end
    end
    wire [4:0] irq_clr = (apb_wr && hit_stat) ? pwdata_in[4:0] : 5'h00;
    wire [4:0] irq_stat = change_reg;
    // Flag value after both clear paths; a set still wins
    wire [4:0] change_final = change_next & ~(irq_clr & ~chg_set);

    // Enable flag
    wire enable_next = !pwr_s ? 1'b0 : hw_dis ? 1'b0 : ((reset_end || resume_end) && conn_eff) ? 1'b1
        : c_clr_en ? 1'b0 : (c_set_en && conn_eff) ? 1'b1 : enable_reg;

    // Read data mux
    wire [31:0] port_word = {11'h000, change_reg, 7'h00, pwr_s, 3'h0, resetting, oc_eff, suspended,
        enable_reg, conn_eff};
    wire [31:0] rd_word = hit_port ? port_word : hit_stat ? {27'h000_0000, irq_stat}
        : hit_mask ? {27'h000_0000, mask_reg} : hit_cfg ? {30'h0000_0000, cfg_reg} : 32'h0000_0000;

    // State registers
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_reg <= rh_port_pkg::st_idle;
            enable_reg <= 1'b0;
            change_reg <= rh_port_pkg::change_reset;
            conn_prev_reg <= 1'b0;
            oc_prev_reg <= 1'b0;
            pend_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            enable_reg <= enable_next;
            change_reg <= change_final;
            conn_prev_reg <= conn_eff;
            oc_prev_reg <= oc_eff;
            pend_reg <= cmd_go ? 5'h00 : (pend_reg | (port_wr ? pwdata_in[4:0] : 5'h00));
        end
    end

    // Software configuration and outputs
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            mask_reg <= rh_port_pkg::irq_mask_reset;
            cfg_reg <= rh_port_pkg::cfg_reset;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
            port_reset_drive_out <= 1'b0;
            port_resume_drive_out <= 1'b0;
            port_eop_drive_out <= 1'b0;
        end else begin
            if (apb_wr && hit_mask) mask_reg <= pwdata_in[4:0];
            if (apb_wr && hit_cfg) cfg_reg <= pwdata_in[1:0];
            pready_out <= psel_in && !pready_out;
            pslverr_out <= psel_in && !pready_out && !hit_any;
            prdata_out <= (psel_in && !pwrite_in) ? rd_word : 32'h0000_0000;
            irq_out <= |(change_final & mask_reg);
            port_reset_drive_out <= state_next == rh_port_pkg::st_reset;
            port_resume_drive_out <= state_next == rh_port_pkg::st_resume;
            port_eop_drive_out <= state_next == rh_port_pkg::st_eop;
        end
    end

    // Checks
    a_no_enable_disc: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !conn_eff |=> !enable_reg) else $error("enable set while disconnected");
    a_reset_end_flags: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        reset_end && conn_eff && !hw_dis |=> change_reg[4] && enable_reg && !resetting)
        else $error("reset end flags wrong");
    a_bad_cmd_chg: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        bad_cmd |=> change_reg[0]) else $error("connect change missing");
    a_busy_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        transact_busy_in && state_reg == rh_port_pkg::st_idle && pwr_s |=> state_reg == rh_port_pkg::st_idle)
        else $error("state changed during transaction");
    a_resume_needs_susp: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        state_reg != rh_port_pkg::st_suspend |=> state_reg != rh_port_pkg::st_resume
        || $past(state_reg) == rh_port_pkg::st_resume) else $error("resume without suspend");
    a_power_off_clr: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !pwr_s |=> !enable_reg && state_reg == rh_port_pkg::st_idle) else $error("power off kept state");
    a_hw_dis_chg: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        hw_dis |=> change_reg[1] && !enable_reg) else $error("enable change missing");
    a_oc_zero: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !cfg_reg[1] |-> !port_word[3]) else $error("over-current shown unsupported");

    // Command and run steps of the port sequencer
    sequence s_reset_cmd;
        c_reset && conn_eff && (state_reg == rh_port_pkg::st_idle || state_reg == rh_port_pkg::st_suspend);
    endsequence
    sequence s_reset_run;
        resetting && port_reset_drive_out;
    endsequence
    sequence s_resume_cmd;
        state_reg == rh_port_pkg::st_suspend && c_resume && !c_reset && !hcres_s && conn_eff;
    endsequence
    sequence s_resume_run;
        state_reg == rh_port_pkg::st_resume && port_resume_drive_out && !port_eop_drive_out;
    endsequence

    // Sequencer step checks
    a_reset_start: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_reset_cmd |=> s_reset_run) else $error("port reset did not start");
    a_reset_hold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        resetting && !tmr_done && conn_eff |=> s_reset_run) else $error("port reset cut short");
    a_resume_start: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s_resume_cmd |=> s_resume_run) else $error("resume did not start");
    a_suspend_enter: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        state_reg == rh_port_pkg::st_idle && c_susp && !c_reset && conn_eff |=> suspended)
        else $error("suspend not entered");
    a_clear_enable: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        c_clr_en && !reset_end && !resume_end |=> !enable_reg) else $error("enable clear ignored");
    a_host_resume: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        hcres_s && suspended && !c_reset |=> !suspended) else $error("host resume kept suspend");
endmodule : rh_port_ctrl

// ==== tb/usb_dev_model.sv ====
// Behavioural USB device on the downstream port
`timescale 1ns/1ps
module usb_dev_model (
    // Clock
    input wire logic sys_clk_in,
    // Bench controls
    input wire logic attach_in,
    input wire logic fault_in,
    input wire logic babble_req_in,
    input wire logic [7:0] txn_len_in,
    // Port lines
    output logic connect_out = 1'b0,
    output logic overcur_out = 1'b0,
    output logic babble_out = 1'b0,
    output logic busy_out
);
    logic [7:0] txn_cnt_reg = 8'h00;
    // Lines follow the controls one edge later
    always_ff @(posedge sys_clk_in) begin
        connect_out <= attach_in;
        overcur_out <= fault_in;
        babble_out <= babble_req_in;
        if (txn_len_in != 8'h00) begin
            txn_cnt_reg <= txn_len_in;
        end else if (txn_cnt_reg != 8'h00) begin
            txn_cnt_reg <= txn_cnt_reg - 8'h01;
        end
    end
    // Busy while a transaction is in flight
    assign busy_out = (txn_cnt_reg != 8'h00);
endmodule : usb_dev_model

// ==== tb/tb.sv ====
// Self-checking bench for the root hub port two block
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, rst_drv, res_drv, eop_drv, irq;
    logic power = 1'b1, hc_resume = 1'b0, attach = 1'b0, fault = 1'b0, babble_req = 1'b0;
    logic [7:0] txn_len = 8'h00;
    logic connect, overcur, babble, busy;
    logic [31:0] cmd [3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0010};
    int mismatches = 0;
    int checks = 0;
    localparam logic [11:0] port_a = rh_port_pkg::port_two_addr;
    // Clock at 50 ns
    initial forever #25 sys_clk = ~sys_clk;
    rh_port_ctrl uut (.sys_clk_in(sys_clk), .reset_in(reset), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .connect_in(connect), .overcur_in(overcur),
        .power_in(power), .babble_in(babble), .transact_busy_in(busy), .hc_resume_in(hc_resume),
        .port_reset_drive_out(rst_drv), .port_resume_drive_out(res_drv),
        .port_eop_drive_out(eop_drv), .irq_out(irq));
    usb_dev_model model (.sys_clk_in(sys_clk), .attach_in(attach), .fault_in(fault),
        .babble_req_in(babble_req), .txn_len_in(txn_len), .connect_out(connect),
        .overcur_out(overcur), .babble_out(babble), .busy_out(busy));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) mismatches++;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata & m, exp);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    // Hang guard, far beyond the expected run
    initial begin
        #1000000;
        mismatches++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        tick(2); // Pins pass two sync flops
        rd(port_a, 32'hffff_ffff, 32'h0000_0100);
        rd(12'h0ff0, 32'hffff_ffff, 32'h0000_0000);
        check(32'(rerr), 32'h0000_0001);
        // Set commands on an empty port only raise connect change
        foreach (cmd[i]) begin
            wr(port_a, cmd[i]);
            rd(port_a, 32'h0001_001f, 32'h0001_0000);
            wr(port_a, 32'h0001_0000);
        end
        // Attach, then interrupt masking and clearing
        attach <= 1'b1;
        tick(5);
        rd(port_a, 32'h0001_0003, 32'h0001_0001);
        check(32'(irq), 32'h0000_0000);
        wr(rh_port_pkg::irq_mask_addr, 32'h0000_0001);
        tick(2);
        check(32'(irq), 32'h0000_0001);
        wr(rh_port_pkg::irq_status_addr, 32'h0000_0001);
        tick(2);
        check(32'(irq), 32'h0000_0000);
        rd(port_a, 32'h0001_0000, 32'h0000_0000);
        // Enable set and clear by writes
        wr(port_a, 32'h0000_0000);
        rd(port_a, 32'h0000_0003, 32'h0000_0001);
        wr(port_a, 32'h0000_0002);
        rd(port_a, 32'h0000_0003, 32'h0000_0003);
        wr(port_a, 32'h0000_0001);
        rd(port_a, 32'h0002_0003, 32'h0000_0001);
        // Write during a bus transaction is held back
        txn_len <= 8'h28;
        tick(1);
        txn_len <= 8'h00;
        wr(port_a, 32'h0000_0002);
        rd(port_a, 32'h0000_0002, 32'h0000_0000);
        tick(45);
        rd(port_a, 32'h0000_0002, 32'h0000_0002);
        // Babble drops enable and flags it
        babble_req <= 1'b1;
        tick(5);
        rd(port_a, 32'h0002_0002, 32'h0002_0000);
        babble_req <= 1'b0;
        wr(port_a, 32'h0002_0000);
        // Port reset runs and is not cut short
        wr(port_a, 32'h0000_0010);
        rd(port_a, 32'h0010_0010, 32'h0000_0010);
        check(32'(rst_drv), 32'h0000_0001);
        tick(1000);
        check(32'(rst_drv), 32'h0000_0001);
        rd(port_a, 32'h0010_0010, 32'h0000_0010);
        // Mid-run system reset drops port reset; enable, already cleared by babble, reads 0
        reset <= 1'b1;
        tick(3);
        reset <= 1'b0;
        tick(3);
        check(32'(rst_drv), 32'h0000_0000);
        rd(port_a, 32'h0000_011e, 32'h0000_0100);
        // Power off clears the state flags
        power <= 1'b0;
        tick(5);
        rd(port_a, 32'h0000_001f, 32'h0000_0000);
        power <= 1'b1;
        tick(5);
        // Resume only from suspend; host resume drops suspend
        wr(port_a, 32'h0000_0008);
        tick(2);
        check(32'(res_drv), 32'h0000_0000);
        wr(port_a, 32'h0000_0004);
        rd(port_a, 32'h0000_0004, 32'h0000_0004);
        wr(port_a, 32'h0000_0008);
        rd(port_a, 32'h0000_0004, 32'h0000_0004);
        check(32'(res_drv), 32'h0000_0001);
        check(32'(eop_drv), 32'h0000_0000);
        hc_resume <= 1'b1;
        tick(5);
        rd(port_a, 32'h0000_0004, 32'h0000_0000);
        check(32'(res_drv), 32'h0000_0000);
        hc_resume <= 1'b0;
        // Nonremovable device reads connected
        attach <= 1'b0;
        wr(rh_port_pkg::port_cfg_addr, 32'h0000_0001);
        tick(5);
        rd(port_a, 32'h0000_0001, 32'h0000_0001);
        wr(rh_port_pkg::port_cfg_addr, 32'h0000_0000);
        rd(port_a, 32'h0000_0001, 32'h0000_0000);
        // Over-current shown only with per-port reporting
        fault <= 1'b1;
        tick(5);
        rd(port_a, 32'h0000_0008, 32'h0000_0000);
        wr(rh_port_pkg::port_cfg_addr, 32'h0000_0002);
        rd(port_a, 32'h0000_0008, 32'h0000_0008);
        print_verdict();
    end
endmodule : tb
